// ### hw/ufc_defs.svh
// Behaviour
// - Loopback feeds receiver from transmit pin
// - Stop field resets one; half: no check
// - One-and-half or two sent, first checked
// - Parity none, even, odd; async only
// - Frame length is field plus three
// - Auto send follows selected trigger level
// - Trigger rising edge sets transmitter enable
// - Trigger rising edge sets receiver enable
// - Select picks trigger channel zero to five
// - Role-off clears controller flag; role-on sets
// - Receiver disable drops frame in progress
// - Receiver enable starts reception from pin
// - Full flag tracks buffer; shifter holds one more
// - Complete flag set when a stop ends with buffer empty, cleared on write
// - Floating flag reads zero under automatic float
// - Discard flag blocks finished frame from buffer
// - I2S next read channel flag
// - I2S send expects right channel flag
`ifndef UFC_DEFS_SVH
`define UFC_DEFS_SVH
`define UFC_OFS_FRAME     12'h004
`define UFC_OFS_TRIG      12'h008
`define UFC_OFS_CMD       12'h00c
`define UFC_OFS_STATUS    12'h010
`define UFC_OFS_CTRL      12'h000
`define UFC_OFS_TXDATA    12'h030
`define UFC_OFS_RXDATA    12'h01c
`define UFC_FRAME_RESET   32'h0000_1005
`define UFC_DATA_LSB      0
`define UFC_PAR_LSB       8
`define UFC_STOP_LSB      12
`define UFC_TRIGGER_CHANNEL_SELECT_LSB      0
`define UFC_RECEIVE_TRIGGER_ENABLE_BIT     4
`define UFC_SEND_TRIGGER_ENABLE_BIT     5
`define UFC_AUTOMATIC_SEND_BIT    6
`define UFC_CMD_RECEIVER_ENABLE_CMD      0
`define UFC_CMD_RECEIVER_DISABLE_CMD     1
`define UFC_CMD_TRANSMITTER_ENABLE_CMD      2
`define UFC_CMD_TXDIS     3
`define UFC_CMD_MEN       4
`define UFC_CMD_MDIS      5
`define UFC_CMD_BLKEN     6
`define UFC_CMD_BLKDIS    7
`define UFC_CMD_TRIEN     8
`define UFC_CMD_TRIDIS    9
`define UFC_CMD_CLRTX     10
`define UFC_CMD_CLRRX     11
`define UFC_CTRL_LOOP     8
`define UFC_CTRL_SYNC     0
`define UFC_CTRL_AUTOMATIC_OUTPUT_FLOAT  29
`define UFC_CTRL_I2S      30
`define UFC_DIV_DEFAULT   16'h00d9
`define UFC_TRIG_CH       6
`define UFC_FIFO_DEPTH    2
`endif

// ### hw/ufc_pkg.sv
package ufc_pkg;
  typedef enum logic [1:0] {
    UFC_PAR_NONE = 2'h0,
    UFC_PAR_EVEN = 2'h2,
    UFC_PAR_ODD  = 2'h3
  } ufc_par_t;
  typedef enum logic [1:0] {
    UFC_ST_IDLE  = 2'b00,
    UFC_ST_START = 2'b01,
    UFC_ST_BITS  = 2'b11,
    UFC_ST_STOP  = 2'b10
  } ufc_state_t;
endpackage

// ### hw/ufc_buf.sv
`timescale 1ns/1ns
`default_nettype none
// Two-word buffer, read data registered
module ufc_buf #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic      [WIDTH-1:0] rd_data,
  output logic                  full
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp;
  logic [AW-1:0]    rp;
  logic [AW:0]      cnt;
  logic             do_wr;
  logic             do_rd;

  // Handshakes
  assign full     = (cnt == (AW+1)'(DEPTH));
  assign wr_ready = !full;
  assign rd_valid = (cnt != '0);
  assign do_wr    = wr_valid && wr_ready && !flush;
  assign do_rd    = rd_valid && rd_ready && !flush;

  // Storage
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wp] <= wr_data;
    end
  end

  // Pointers and count; flush empties
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else if (flush) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      if (do_wr) begin
        wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
      end
      if (do_rd) begin
        rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
      end
      cnt <= cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  // Registered head word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (do_wr && (cnt == '0 || (do_rd && cnt == 1))) begin
      rd_data <= wr_data;
    end else if (do_rd) begin
      rd_data <= mem[(rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1];
    end
  end
endmodule
`default_nettype wire

// ### hw/ufc_top.sv
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ufc_defs.svh"
// Frame format, trigger, command and status part of the serial unit
module ufc_top #(
  parameter logic [15:0] BIT_DIV = `UFC_DIV_DEFAULT
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [5:0]  on_chip_trigger_network,
  input  wire logic        rx_pin,
  output logic             tx_out,
  output logic             tx_oe,
  output logic             automatic_send
);
  import ufc_pkg::*;

  logic        rst_s1, rst_s2;
  logic [31:0] frame_format, trigger_control, main_control_register;
  logic [15:0] bit_cnt;
  logic        bit_tick, half_tick;
  logic        wr_acc, rd_acc;
  logic [11:0] cmd;
  logic        transmitter_enabled_flag, receiver_enabled, controller_role;
  logic        receive_discard_flag, output_float, send_complete_flag;
  logic        next_read_right_channel, send_expects_right_single;
  logic [1:0]  rx_sync;
  logic [5:0]  trg_s1, trg_s2, trg_q;
  logic        trg_lvl, trg_rise;
  logic        rx_line;
  logic        txw_valid, txw_ready, txb_valid, txb_take, txb_full;
  logic [15:0] txb_data;
  logic        rxw_valid, rxw_ready, rxb_valid, rxb_take, receive_buffer_full_flag;
  logic [17:0] rxb_data, rx_word;
  logic [4:0]  nbits;
  logic [1:0]  par_sel, stop_sel;
  ufc_state_t  tx_st, rx_st;
  logic [4:0]  tx_idx, rx_idx;
  logic [2:0]  tx_half;
  logic [16:0] tx_sh;
  logic        tx_par, tx_busy;
  logic [16:0] rx_sh;
  logic        rx_par, rx_perr, rx_ferr, rx_has_par;
  logic [15:0] rx_cnt;

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // APB: zero wait states, never errors
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;
  assign cmd     = (wr_acc && paddr == `UFC_OFS_CMD) ? pwdata[11:0] : 12'h000;

  // Configuration registers
  always_ff @(posedge core_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      frame_format          <= `UFC_FRAME_RESET;
      trigger_control       <= 32'h0000_0000;
      main_control_register <= 32'h0000_0000;
    end else if (wr_acc) begin
      case (paddr)
        `UFC_OFS_FRAME: frame_format <= pwdata & 32'h0000_330f;
        `UFC_OFS_TRIG:  trigger_control <= pwdata & 32'h0000_0077;
        `UFC_OFS_CTRL:  main_control_register <= pwdata & 32'h6000_0101;
        default: ;
      endcase
    end
  end

  // Read mux; command register reads zero
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_acc) begin
      case (paddr)
        `UFC_OFS_CTRL:   prdata = main_control_register;
        `UFC_OFS_FRAME:  prdata = frame_format;
        `UFC_OFS_TRIG:   prdata = trigger_control;
        `UFC_OFS_CMD:    prdata = 32'h0000_0000;
        `UFC_OFS_STATUS: prdata = {19'h0_0000, 1'b0,
          main_control_register[`UFC_CTRL_I2S] & next_read_right_channel,
          main_control_register[`UFC_CTRL_I2S] & send_expects_right_single,
          1'b0, receive_buffer_full_flag, rxb_valid, !txb_valid,
          send_complete_flag,
          output_float & !main_control_register[`UFC_CTRL_AUTOMATIC_OUTPUT_FLOAT],
          receive_discard_flag, controller_role, transmitter_enabled_flag,
          receiver_enabled};
        `UFC_OFS_RXDATA: prdata = {15'h0000, rxb_data[16:0]};
        default:         prdata = 32'h0000_0000;
      endcase
    end
  end

  // Bit-rate divider; one enable per bit period
  always_ff @(posedge core_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      bit_cnt <= 16'h0000;
    end else begin
      bit_cnt <= (bit_cnt == BIT_DIV) ? 16'h0000 : bit_cnt + 16'h0001;
    end
  end
  assign bit_tick  = (bit_cnt == BIT_DIV);
  assign half_tick = bit_tick || (bit_cnt == (BIT_DIV >> 1));

  // Pin and trigger synchronisers
  always_ff @(posedge core_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      rx_sync <= 2'b11;
      trg_s1  <= 6'h00;
      trg_s2  <= 6'h00;
      trg_q   <= 6'h00;
    end else begin
      rx_sync <= {rx_sync[0], rx_pin};
      trg_s1  <= on_chip_trigger_network;
      trg_s2  <= trg_s1;
      trg_q   <= trg_s2;
    end
  end

  // Selected trigger level and rising edge
  always_comb begin
    trg_lvl  = 1'b0;
    trg_rise = 1'b0;
    if (trigger_control[2:0] < 3'(`UFC_TRIG_CH)) begin
      trg_lvl  = trg_s2[trigger_control[2:0]];
      trg_rise = trg_s2[trigger_control[2:0]] & !trg_q[trigger_control[2:0]];
    end
  end
  assign automatic_send = trigger_control[`UFC_AUTOMATIC_SEND_BIT] & trg_lvl;

  // Enables, role, block and float; set wins over clear
  always_ff @(posedge core_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      transmitter_enabled_flag <= 1'b0;
      receiver_enabled         <= 1'b0;
      controller_role          <= 1'b0;
      receive_discard_flag     <= 1'b0;
      output_float             <= 1'b0;
    end else begin
      if (cmd[`UFC_CMD_TXDIS]) transmitter_enabled_flag <= 1'b0;
      if (cmd[`UFC_CMD_TRANSMITTER_ENABLE_CMD] || (trigger_control[`UFC_SEND_TRIGGER_ENABLE_BIT] && trg_rise)) begin
        transmitter_enabled_flag <= 1'b1;
      end
      if (cmd[`UFC_CMD_RECEIVER_DISABLE_CMD]) receiver_enabled <= 1'b0;
      if (cmd[`UFC_CMD_RECEIVER_ENABLE_CMD] || (trigger_control[`UFC_RECEIVE_TRIGGER_ENABLE_BIT] && trg_rise)) begin
        receiver_enabled <= 1'b1;
      end
      if (cmd[`UFC_CMD_MDIS]) controller_role <= 1'b0;
      if (cmd[`UFC_CMD_MEN]) controller_role <= 1'b1;
      if (cmd[`UFC_CMD_BLKDIS]) receive_discard_flag <= 1'b0;
      if (cmd[`UFC_CMD_BLKEN]) receive_discard_flag <= 1'b1;
      if (cmd[`UFC_CMD_TRIDIS]) output_float <= 1'b0;
      if (cmd[`UFC_CMD_TRIEN]) output_float <= 1'b1;
    end
  end

  // Frame format fields
  assign nbits    = 5'(frame_format[3:0]) + 5'd3;
  assign par_sel  = frame_format[9:8];
  assign stop_sel = frame_format[13:12];
  assign rx_has_par = (par_sel == UFC_PAR_EVEN || par_sel == UFC_PAR_ODD) &&
                      !main_control_register[`UFC_CTRL_SYNC];

  // Transmit buffer fed by data writes
  assign txw_valid = wr_acc && paddr == `UFC_OFS_TXDATA;
  ufc_buf #(.WIDTH(16), .DEPTH(`UFC_FIFO_DEPTH)) u_txbuf (
    .clk      (core_clk),
    .rst_n    (rst_s2),
    .flush    (cmd[`UFC_CMD_CLRTX]),
    .wr_valid (txw_valid),
    .wr_ready (txw_ready),
    .wr_data  (pwdata[15:0]),
    .rd_valid (txb_valid),
    .rd_ready (txb_take),
    .rd_data  (txb_data),
    .full     (txb_full)
  );
  assign txb_take = txb_valid && tx_st == UFC_ST_IDLE && transmitter_enabled_flag && bit_tick;

  // Transmitter; stop length counted in half bits
  always_ff @(posedge core_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      tx_st   <= UFC_ST_IDLE;
      tx_sh   <= 17'h1_ffff;
      tx_idx  <= 5'd0;
      tx_half <= 3'd0;
      tx_out  <= 1'b1;
      tx_par  <= 1'b0;
    end else if (cmd[`UFC_CMD_CLRTX]) begin
      tx_st  <= UFC_ST_IDLE;
      tx_out <= 1'b1;
    end else begin
      case (tx_st)
        UFC_ST_IDLE: if (txb_take) begin
          tx_sh  <= {1'b0, txb_data};
          tx_par <= (par_sel == UFC_PAR_ODD);
          tx_out <= 1'b0;
          tx_idx <= 5'd0;
          tx_st  <= UFC_ST_BITS;
        end
        UFC_ST_BITS: if (bit_tick) begin
          if (tx_idx < nbits) begin
            tx_out <= tx_sh[0];
            tx_par <= tx_par ^ tx_sh[0];
            tx_sh  <= {1'b1, tx_sh[16:1]};
            tx_idx <= tx_idx + 5'd1;
          end else if (tx_idx == nbits && rx_has_par) begin
            tx_out <= tx_par;
            tx_idx <= tx_idx + 5'd1;
          end else begin
            tx_out  <= 1'b1;
            tx_half <= 3'(stop_sel) + 3'd1;
            tx_st   <= UFC_ST_STOP;
          end
        end
        UFC_ST_STOP: if (half_tick) begin
          tx_half <= tx_half - 3'd1;
          if (tx_half == 3'd1) tx_st <= UFC_ST_IDLE;
        end
        default: tx_st <= UFC_ST_IDLE;
      endcase
    end
  end
  assign tx_busy = (tx_st != UFC_ST_IDLE);
  assign tx_oe   = !(output_float && !main_control_register[`UFC_CTRL_AUTOMATIC_OUTPUT_FLOAT]) &&
                   !(main_control_register[`UFC_CTRL_AUTOMATIC_OUTPUT_FLOAT] && !tx_busy);

  // Complete flag: set when a stop ends with buffer empty, write clears; set wins
  always_ff @(posedge core_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      send_complete_flag        <= 1'b0;
      send_expects_right_single <= 1'b0;
    end else begin
      if (txw_valid && txw_ready) begin
        send_complete_flag        <= 1'b0;
        send_expects_right_single <= !send_expects_right_single;
      end
      if (tx_st == UFC_ST_STOP && half_tick && tx_half == 3'd1 && !txb_valid) begin
        send_complete_flag <= 1'b1;
      end
      if (cmd[`UFC_CMD_CLRTX]) send_expects_right_single <= 1'b0;
    end
  end

  // Receiver input, loopback from transmit pin
  assign rx_line = main_control_register[`UFC_CTRL_LOOP] ? tx_out : rx_sync[1];

  // Receiver: sample mid-bit, shift word, one stop check
  always_ff @(posedge core_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      rx_st   <= UFC_ST_IDLE;
      rx_cnt  <= 16'h0000;
      rx_idx  <= 5'd0;
      rx_sh   <= 17'h0_0000;
      rx_par  <= 1'b0;
      rx_perr <= 1'b0;
      rx_ferr <= 1'b0;
      rx_word <= 18'h0_0000;
      rxw_valid <= 1'b0;
    end else begin
      // Finished word waits here while the buffer is full
      if (rxw_ready || cmd[`UFC_CMD_CLRRX]) rxw_valid <= 1'b0;
      if (!receiver_enabled || cmd[`UFC_CMD_RECEIVER_DISABLE_CMD] || cmd[`UFC_CMD_CLRRX]) begin
        rx_st <= UFC_ST_IDLE;
      end else begin
        rx_cnt <= (rx_cnt == BIT_DIV) ? 16'h0000 : rx_cnt + 16'h0001;
        case (rx_st)
          UFC_ST_IDLE: if (!rx_line) begin
            rx_cnt <= 16'h0000;
            rx_st  <= UFC_ST_START;
          end
          UFC_ST_START: if (rx_cnt == (BIT_DIV >> 1)) begin
            rx_cnt <= 16'h0000;
            rx_idx <= 5'd0;
            rx_sh  <= 17'h0_0000;
            rx_par <= (par_sel == UFC_PAR_ODD);
            rx_st  <= rx_line ? UFC_ST_IDLE : UFC_ST_BITS;
          end
          UFC_ST_BITS: if (rx_cnt == BIT_DIV) begin
            rx_idx <= rx_idx + 5'd1;
            rx_par <= rx_par ^ rx_line;
            if (rx_idx < nbits) begin
              rx_sh[rx_idx] <= rx_line;
            end else if (rx_idx == nbits && rx_has_par) begin
              rx_perr <= rx_par ^ rx_line;
            end else begin
              rx_ferr   <= (stop_sel != 2'd0) && !rx_line;
              if (!receive_discard_flag) begin
                rx_word   <= {(stop_sel != 2'd0) && !rx_line, rx_perr, rx_sh[15:0]};
                rxw_valid <= 1'b1;
              end
              rx_st     <= UFC_ST_IDLE;
            end
            if (!(rx_idx == nbits && rx_has_par)) rx_perr <= rx_idx < nbits ? 1'b0 : rx_perr;
          end
          default: rx_st <= UFC_ST_IDLE;
        endcase
      end
    end
  end

  // Receive buffer; finished frame waits one slot in the shifter
  ufc_buf #(.WIDTH(18), .DEPTH(`UFC_FIFO_DEPTH)) u_rxbuf (
    .clk      (core_clk),
    .rst_n    (rst_s2),
    .flush    (cmd[`UFC_CMD_CLRRX]),
    .wr_valid (rxw_valid),
    .wr_ready (rxw_ready),
    .wr_data  (rx_word),
    .rd_valid (rxb_valid),
    .rd_ready (rxb_take),
    .rd_data  (rxb_data),
    .full     (receive_buffer_full_flag)
  );
  assign rxb_take = rd_acc && paddr == `UFC_OFS_RXDATA;

  // I2S channel of next receive read
  always_ff @(posedge core_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      next_read_right_channel <= 1'b0;
    end else if (cmd[`UFC_CMD_CLRRX]) begin
      next_read_right_channel <= 1'b0;
    end else if (rxb_take && rxb_valid) begin
      next_read_right_channel <= !next_read_right_channel;
    end
  end
endmodule
`default_nettype wire

// ### testbench/ufc_top_properties.sv
`timescale 1ns/1ns
`default_nettype none
// Port-level checks of the register side, line enable and trigger level
module ufc_top_properties (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [5:0]  on_chip_trigger_network,
  input wire logic        rx_pin,
  input wire logic        tx_out,
  input wire logic        tx_oe,
  input wire logic        automatic_send
);
  logic        wr;
  logic        rd;
  logic [31:0] frame_sh;
  logic [6:0]  trig_sh;
  logic        auto_tri;
  logic        role;
  logic        blk;
  logic        flt;
  logic        flt_known;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  // Shadows of what software wrote; automatic float makes the float state unknown
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_sh  <= 32'h0000_1005;
      trig_sh   <= 7'h00;
      auto_tri  <= 1'b0;
      {role, blk, flt} <= 3'h0;
      flt_known <= 1'b1;
    end else if (wr) begin
      if (paddr == 12'h004) frame_sh <= pwdata & 32'h0000_330f;
      if (paddr == 12'h008) trig_sh <= pwdata[6:0] & 7'h77;
      if (paddr == 12'h000) auto_tri <= pwdata[29];
      if (paddr == 12'h000 && pwdata[29]) flt_known <= 1'b0;
      if (paddr == 12'h00c) begin
        role <= pwdata[4] | (role & !pwdata[5]);
        blk  <= pwdata[6] | (blk & !pwdata[7]);
        flt  <= pwdata[8] | (flt & !pwdata[9]);
        if (pwdata[8] || pwdata[9]) flt_known <= 1'b1;
      end
    end
  end
  a_cmd_reads_zero: assert property (
    rd && paddr == 12'h00c |-> prdata == 32'h0000_0000) else $error("command word read nonzero");
  a_float_cmd_oe: assert property (
    wr && paddr == 12'h00c && pwdata[8] |=> !tx_oe) else $error("output still driven after float");
  a_oe_follows_flag: assert property (
    flt_known && !auto_tri |-> tx_oe == !flt) else $error("output enable disagrees with float");
  a_role_block_flags: assert property (
    rd && paddr == 12'h010 |-> prdata[3:2] == {blk, role}) else $error("role or discard flag wrong");
  a_float_flag_read: assert property (
    rd && paddr == 12'h010 && (auto_tri || flt_known) |-> prdata[4] == (!auto_tri && flt))
    else $error("floating flag wrong");
  a_frame_readback: assert property (
    rd && paddr == 12'h004 |-> prdata == frame_sh) else $error("frame format readback wrong");
  a_trig_readback: assert property (
    rd && paddr == 12'h008 |-> prdata == {25'h0, trig_sh}) else $error("trigger readback wrong");
  a_auto_send_level: assert property (
    ($stable(on_chip_trigger_network) && !(wr && paddr == 12'h008))[*3] |->
    automatic_send == (trig_sh[6] && trig_sh[2:0] < 3'h6 && on_chip_trigger_network[trig_sh[2:0]]))
    else $error("automatic send level wrong");
endmodule
bind ufc_top ufc_top_properties u_props (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .on_chip_trigger_network(on_chip_trigger_network),
  .rx_pin(rx_pin), .tx_out(tx_out), .tx_oe(tx_oe), .automatic_send(automatic_send));
`default_nettype wire

// ### testbench/ufc_remote.sv
`timescale 1ns/1ns
`default_nettype none
// Far-end serial device: sends frames on its line and decodes what it hears
module ufc_remote #(
  parameter int BIT_CLKS = 4
) (
  input  wire logic clk,
  input  wire logic line_in,
  output logic      line_out
);
  int          nbits;
  int          count;
  logic [1:0]  par;
  logic [15:0] got;
  logic        got_par;
  logic        got_stop;
  // One bit held for a whole bit period
  task automatic put(input logic b);
    line_out <= b;
    repeat (BIT_CLKS) @(posedge clk);
  endtask
  // Start, data low bit first, optional parity, one stop
  task automatic send(input logic [15:0] d);
    logic p;
    p = par[0];
    put(1'b0);
    for (int i = 0; i < nbits; i++) begin
      put(d[i]);
      p ^= d[i];
    end
    if (par[1]) put(p);
    put(1'b1);
  endtask
  // Receiver samples mid-bit; only the first stop bit is looked at
  initial begin
    line_out = 1'b1;
    {nbits, count, par} = {32'd8, 32'd0, 2'h0};
    forever begin
      @(posedge clk);
      if (line_in === 1'b0) begin
        repeat (BIT_CLKS / 2) @(posedge clk);
        got = 16'h0000;
        for (int i = 0; i < nbits; i++) begin
          repeat (BIT_CLKS) @(posedge clk);
          got[i] = line_in;
        end
        if (par[1]) begin
          repeat (BIT_CLKS) @(posedge clk);
          got_par = line_in;
        end
        repeat (BIT_CLKS) @(posedge clk);
        got_stop = line_in;
        count++;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/usart_frame_command_status_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "ufc_defs.svh"
// Frame format, triggers, commands and status through the register bus
module usart_frame_command_status_bench;
  localparam logic [11:0] CTL = `UFC_OFS_CTRL;
  localparam logic [11:0] FRM = `UFC_OFS_FRAME;
  localparam logic [11:0] TRG = `UFC_OFS_TRIG;
  localparam logic [11:0] CMD = `UFC_OFS_CMD;
  localparam logic [11:0] STA = `UFC_OFS_STATUS;
  localparam logic [11:0] TXD = `UFC_OFS_TXDATA;
  localparam logic [11:0] RXD = `UFC_OFS_RXDATA;
  logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [5:0]  trig;
  logic        rx_pin, tx_out, tx_oe, auto_send, line;
  int          miscompares, n_checks;
  int          cycles = 0;
  ufc_top #(.BIT_DIV(16'h0003)) u_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .on_chip_trigger_network(trig), .rx_pin(rx_pin),
    .tx_out(tx_out), .tx_oe(tx_oe), .automatic_send(auto_send));
  ufc_remote #(.BIT_CLKS(4)) u_far (.clk(core_clk), .line_in(line), .line_out(rx_pin));
  // Pulled-up line, so a floating transmitter reads as idle
  assign line = tx_oe ? tx_out : 1'b1;
  always #20 core_clk = ~core_clk;
  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // One bus transfer; held until pready is seen, then one idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    q = prdata;
    {psel, penable} <= 2'b00;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), e, q & m);
  endtask
  // Poll receive-valid with a bound
  task automatic rxwait;
    int k;
    k = 0;
    do begin
      apb(1'b0, STA, 32'h0);
      k++;
    end while (q[7] !== 1'b1 && k < 60);
  endtask
  // Send one word in loopback; the far end and the receiver both judge it
  task automatic lb(input logic [31:0] f, input int n, input logic [1:0] p, input logic [15:0] d);
    logic [15:0] m;
    int          c;
    m = 16'hffff >> (16 - n);
    c = u_far.count;
    u_far.nbits = n;
    u_far.par = p;
    wr(FRM, f);
    wr(TXD, {16'h0, d});
    rc(STA, 32'h0, 32'h20);
    for (int k = 0; k < 400 && u_far.count == c; k++) @(posedge core_clk);
    chk("line data", d & m, u_far.got & m);
    if (p[1]) chk("line parity", p[0] ^ (^(d & m)), u_far.got_par);
    chk("line stop", 1, u_far.got_stop);
    rxwait();
    rc(RXD, d & m, m);
    rc(STA, 32'h20, 32'h20);
  endtask
  initial begin
    {core_clk, rst_n, psel, penable, pwrite, paddr, pwdata, trig} = '0;
    {miscompares, n_checks} = '0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    // Reset values, a hole in the map, trigger readback
    rc(FRM, 32'h0000_1005, '1);
    rc(CMD, 32'h0, '1);
    rc(STA, 32'h0000_0040, '1);
    rc(12'h100, 32'h0, '1);
    wr(TRG, 32'h0000_0075);
    rc(TRG, 32'h0000_0075, '1);
    $display("test registers done");
    // Set/clear pairs each move one status bit; a zero write moves nothing; line enable low only after float on
    for (int i = 0; i < 10; i++) begin
      wr(CMD, 32'h1 << i);
      if (i % 2 == 0) wr(CMD, 32'h0);
      rc(STA, (i % 2 == 0) ? (32'h1 << (i / 2)) : 32'h0, 32'h1 << (i / 2));
      chk("line enable", i != 8, tx_oe);
    end
    $display("test commands done");
    // Channel 2 selected; channel 3 must not act
    wr(TRG, 32'h0000_0072);
    for (int c = 3; c >= 2; c--) begin
      trig <= 6'h01 << c;
      repeat (4) @(posedge core_clk);
      chk("auto send", c == 2, auto_send);
      rc(STA, (c == 2) ? 32'h3 : 32'h0, 32'h3);
    end
    trig <= 6'h00;
    repeat (4) @(posedge core_clk);
    chk("auto send", 0, auto_send);
    wr(TRG, 32'h0);
    $display("test triggers done");
    // Formats through loopback
    wr(CTL, 32'h0000_0100);
    wr(CMD, 32'h0000_0005);
    lb(32'h0000_1205, 8, 2'h2, 16'h00a5);
    lb(32'h0000_1301, 4, 2'h3, 16'h000b);
    lb(32'h0000_300d, 16, 2'h0, 16'h9c3a);
    lb(32'h0000_2306, 9, 2'h3, 16'h01c5);
    lb(32'h0000_0005, 8, 2'h0, 16'h005a);
    wr(CTL, 32'h0000_0101);
    lb(32'h0000_1205, 8, 2'h0, 16'h00c3);
    $display("test formats done");
    // Frames from the pin: discard, full, mid-frame disable, flush
    wr(CTL, 32'h0);
    wr(FRM, 32'h0000_1005);
    {u_far.nbits, u_far.par} = {32'd8, 2'h0};
    wr(CMD, 32'h0000_0041);
    u_far.send(16'h003c);
    repeat (8) @(posedge core_clk);
    rc(STA, 32'h0, 32'h80);
    wr(CMD, 32'h0000_0080);
    for (int i = 1; i < 4; i++) u_far.send(16'h0011 * i);
    repeat (8) @(posedge core_clk);
    rc(STA, 32'h180, 32'h180);
    for (int i = 1; i < 4; i++) rc(RXD, 32'h0011 * i, 32'hff);
    rc(STA, 32'h0, 32'h180);
    fork
      u_far.send(16'h0077);
      begin
        repeat (16) @(posedge core_clk);
        wr(CMD, 32'h0000_0002);
      end
    join
    wr(CMD, 32'h0000_0001);
    u_far.send(16'h0055);
    rxwait();
    rc(RXD, 32'h55, 32'hff);
    u_far.send(16'h0066);
    rxwait();
    wr(CMD, 32'h0000_0800);
    rc(STA, 32'h0, 32'h80);
    $display("test receive done");
    // Automatic float hides the floating flag; transmit flush restarts channel order
    wr(CTL, 32'h6000_0000);
    wr(CMD, 32'h0000_0100);
    rc(STA, 32'h0, 32'h10);
    wr(CMD, 32'h0000_0400);
    wr(TXD, 32'h0);
    rc(STA, 32'h400, 32'hc00);
    wr(CTL, 32'h0);
    wr(CMD, 32'h0000_0200);
    chk("line enable", 1, tx_oe);
    $display("test float done");
    give_verdict();
  end
endmodule
`default_nettype wire
